// >>> include/vsf_map.svh
// Field positions, reset levels and timing counts of the DMA FIFO block
`ifndef VSF_MAP_SVH
`define VSF_MAP_SVH
`define VSF_CLK_PERIOD_NS 10
`define VSF_RATE_UNIT_NS 1000
`define VSF_US_CYCLES (`VSF_RATE_UNIT_NS / `VSF_CLK_PERIOD_NS)
`define VSF_SND_TEST_BIT 8
`define VSF_SND_RATE_MSB 7
`define VSF_BLOCK_LAST 2'h3
`define VSF_FILL_BLOCKS 2'h2
`define VSF_CUR_REFILL 3'h4
`define VSF_SND_FULL 3'h4
`define VSF_PIN_IDLE 1'b1
`endif

// >>> include/vsf_pkg.sv
// Types shared by the DMA FIFO block
package vsf_pkg;
  typedef struct packed {
    logic hsync_n;
    logic vsync_n;
    logic snd_ack_n;
    logic vid_ack_n;
  } vsf_pins_t;

  typedef enum logic [2:0] {
    VSF_V_IDLE = 3'b001,
    VSF_V_FILL = 3'b010,
    VSF_V_RUN = 3'b100
  } vsf_vstate_t;
endpackage

// >>> hw/vsf_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module vsf_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// >>> hw/vsf_mem.sv
// Small word store with registered read data
`timescale 1ns/10ps
module vsf_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      store[wr_addr] <= wr_data;
    end
    rd_data <= store[rd_addr];
  end
endmodule

// >>> hw/vsf_top.sv
// Sound, video and cursor DMA FIFOs with their request logic
`timescale 1ns/10ps
`include "vsf_map.svh"
module vsf_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sound_dma_ack_n,
  input wire logic video_dma_ack_n,
  input wire logic horizontal_sync_n,
  input wire logic vertical_sync_n,
  input wire logic [31:0] dma_data,
  input wire logic [8:0] sound_rate_reg,
  input wire logic [1:0] request_pointer,
  input wire logic cursor_enable,
  input wire logic cursor_raster,
  input wire logic first_display_raster,
  input wire logic video_byte_take,
  input wire logic cursor_byte_take,
  output logic sound_dma_request_n,
  output logic video_dma_request_n,
  output logic [7:0] sound_byte,
  output logic sound_byte_strobe,
  output logic [7:0] video_byte,
  output logic video_byte_valid,
  output logic [7:0] cursor_byte,
  output logic cursor_byte_valid
);
  localparam logic [6:0] US_LAST = 7'(`VSF_US_CYCLES - 1);

  vsf_pkg::vsf_pins_t pins_raw, pins_s, pins_q;
  logic [31:0] data_s, snd_rdata, vid_rdata, cur_rdata;
  logic snd_ack_rise, vid_ack_rise, hs_fall, hs_rise, hs_active, vs_active;

  assign pins_raw = '{hsync_n: horizontal_sync_n, vsync_n: vertical_sync_n,
                      snd_ack_n: sound_dma_ack_n, vid_ack_n: video_dma_ack_n};

  vsf_sync #(.WIDTH(4), .RESET_VAL(4'hF)) u_pin_sync (
    .core_clk(core_clk), .resetn(resetn), .d(pins_raw), .q(pins_s));
  vsf_sync #(.WIDTH(32), .RESET_VAL(32'h0)) u_data_sync (
    .core_clk(core_clk), .resetn(resetn), .d(dma_data), .q(data_s));

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pins_q <= 4'hF;
    else
      pins_q <= pins_s;
  end

  assign snd_ack_rise = pins_s.snd_ack_n & ~pins_q.snd_ack_n;
  assign vid_ack_rise = pins_s.vid_ack_n & ~pins_q.vid_ack_n;
  assign hs_fall = ~pins_s.hsync_n & pins_q.hsync_n;
  assign hs_rise = pins_s.hsync_n & ~pins_q.hsync_n;
  assign hs_active = ~pins_s.hsync_n;
  assign vs_active = ~pins_s.vsync_n;

  // Sound path
  logic [6:0] us_cnt_reg, us_cnt_next;
  logic [7:0] rate_cnt_reg, rate_cnt_next, snd_byte_next;
  logic [2:0] snd_count_reg, snd_count_next;
  logic [1:0] snd_wr_reg, snd_wr_next, snd_rd_reg, snd_rd_next, snd_idx_reg, snd_idx_next;
  logic snd_req_n_next, snd_strobe_next, snd_wr_en, byte_tick, test_on;

  assign test_on = sound_rate_reg[`VSF_SND_TEST_BIT];
  assign byte_tick = test_on && (us_cnt_reg == US_LAST) && (rate_cnt_reg == 8'h00);
  assign snd_wr_en = snd_ack_rise && (snd_count_reg != `VSF_SND_FULL);

  vsf_mem #(.WIDTH(32), .DEPTH(4)) u_snd_mem (
    .core_clk(core_clk), .wr_en(snd_wr_en), .wr_addr(snd_wr_reg), .wr_data(data_s),
    .rd_addr(snd_rd_reg), .rd_data(snd_rdata));

  always_comb
  begin
    us_cnt_next = 7'h00;
    rate_cnt_next = 8'h00;
    if (test_on)
    begin
      us_cnt_next = (us_cnt_reg == US_LAST) ? 7'h00 : us_cnt_reg + 7'h01;
      rate_cnt_next = rate_cnt_reg;
      if (us_cnt_reg == US_LAST)
        rate_cnt_next = (rate_cnt_reg == 8'h00) ?
          sound_rate_reg[`VSF_SND_RATE_MSB:0] : rate_cnt_reg - 8'h01;
    end
    snd_wr_next = snd_wr_reg;
    snd_rd_next = snd_rd_reg;
    snd_idx_next = snd_idx_reg;
    snd_byte_next = sound_byte;
    snd_strobe_next = 1'b0;
    snd_req_n_next = sound_dma_request_n;
    snd_count_next = snd_count_reg;
    if (byte_tick)
    begin
      if (snd_count_reg != 3'h0)
      begin
        snd_byte_next = snd_rdata[8*snd_idx_reg +: 8];
        snd_strobe_next = 1'b1;
        snd_idx_next = snd_idx_reg + 2'h1;
        if (snd_idx_reg == `VSF_BLOCK_LAST)
        begin
          snd_rd_next = snd_rd_reg + 2'h1;
          snd_count_next = snd_count_reg - 3'h1;
          if (snd_count_reg == 3'h1)
            snd_req_n_next = 1'b0;
        end
      end
      else
        snd_req_n_next = 1'b0;
    end
    if (snd_wr_en)
    begin
      snd_wr_next = snd_wr_reg + 2'h1;
      snd_count_next = snd_count_next + 3'h1;
    end
    if (snd_ack_rise)
      snd_req_n_next = 1'b1;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      us_cnt_reg <= 7'h00;
      rate_cnt_reg <= 8'h00;
      snd_count_reg <= 3'h0;
      snd_wr_reg <= 2'h0;
      snd_rd_reg <= 2'h0;
      snd_idx_reg <= 2'h0;
      sound_byte <= 8'h00;
      sound_byte_strobe <= 1'b0;
      sound_dma_request_n <= `VSF_PIN_IDLE;
    end
    else
    begin
      us_cnt_reg <= us_cnt_next;
      rate_cnt_reg <= rate_cnt_next;
      snd_count_reg <= snd_count_next;
      snd_wr_reg <= snd_wr_next;
      snd_rd_reg <= snd_rd_next;
      snd_idx_reg <= snd_idx_next;
      sound_byte <= snd_byte_next;
      sound_byte_strobe <= snd_strobe_next;
      sound_dma_request_n <= snd_req_n_next;
    end
  end

  // Video and cursor path
  vsf_pkg::vsf_vstate_t vstate_reg, vstate_next;
  logic [3:0] vid_count_reg, vid_count_next;
  logic [2:0] vid_wr_reg, vid_wr_next, vid_rd_reg, vid_rd_next, cur_left_reg, cur_left_next;
  logic [1:0] vid_idx_reg, vid_idx_next, blocks_reg, blocks_next, burst_reg, burst_next;
  logic [1:0] cur_wr_reg, cur_wr_next, cur_rd_reg, cur_rd_next, cur_idx_reg, cur_idx_next;
  logic [7:0] vbyte_next, cbyte_next;
  logic video_first_reg, video_first_next, cur_par_reg, cur_par_next;
  logic vreq_n_next, vvalid_next, cvalid_next, route_vid, route_cur, vid_wr_en, cur_wr_en;

  // Low request during sync serves the cursor unless a video burst leads
  assign route_vid = (blocks_reg != 2'h0) && ((burst_reg != 2'h0) || !hs_active ||
                     video_first_reg || (cur_left_reg == 3'h0));
  assign route_cur = !route_vid && hs_active && (cur_left_reg != 3'h0);
  assign vid_wr_en = vid_ack_rise && route_vid && !vs_active;
  assign cur_wr_en = vid_ack_rise && route_cur;

  vsf_mem #(.WIDTH(32), .DEPTH(8)) u_vid_mem (
    .core_clk(core_clk), .wr_en(vid_wr_en), .wr_addr(vid_wr_reg), .wr_data(data_s),
    .rd_addr(vid_rd_reg), .rd_data(vid_rdata));
  vsf_mem #(.WIDTH(32), .DEPTH(4)) u_cur_mem (
    .core_clk(core_clk), .wr_en(cur_wr_en), .wr_addr(cur_wr_reg), .wr_data(data_s),
    .rd_addr(cur_rd_reg), .rd_data(cur_rdata));

  always_comb
  begin
    vstate_next = vstate_reg;
    vid_count_next = vid_count_reg;
    vid_wr_next = vid_wr_reg;
    vid_rd_next = vid_rd_reg;
    vid_idx_next = vid_idx_reg;
    blocks_next = blocks_reg;
    burst_next = burst_reg;
    video_first_next = video_first_reg;
    cur_left_next = cur_left_reg;
    cur_wr_next = cur_wr_reg;
    cur_rd_next = cur_rd_reg;
    cur_idx_next = cur_idx_reg;
    cur_par_next = cur_par_reg;
    vbyte_next = video_byte;
    cbyte_next = cursor_byte;
    vvalid_next = 1'b0;
    cvalid_next = 1'b0;
    if (hs_fall)
    begin
      video_first_next = (blocks_reg != 2'h0);
      if (cursor_enable && cursor_raster)
      begin
        cur_par_next = ~cur_par_reg;
        if (!cur_par_reg)
        begin
          cur_left_next = `VSF_CUR_REFILL;
          cur_wr_next = 2'h0;
          cur_rd_next = 2'h0;
          cur_idx_next = 2'h0;
        end
      end
      else
        cur_par_next = 1'b0;
    end
    if (cur_wr_en)
    begin
      cur_wr_next = cur_wr_reg + 2'h1;
      cur_left_next = cur_left_reg - 3'h1;
    end
    if (cursor_byte_take)
    begin
      cbyte_next = cur_rdata[8*cur_idx_reg +: 8];
      cvalid_next = 1'b1;
      cur_idx_next = cur_idx_reg + 2'h1;
      if (cur_idx_reg == `VSF_BLOCK_LAST)
        cur_rd_next = cur_rd_reg + 2'h1;
    end
    if (vid_wr_en)
    begin
      vid_wr_next = vid_wr_reg + 3'h1;
      vid_count_next = vid_count_reg + 4'h1;
      burst_next = burst_reg + 2'h1;
      if (burst_reg == `VSF_BLOCK_LAST)
      begin
        blocks_next = blocks_reg - 2'h1;
        video_first_next = 1'b0;
      end
    end
    if (video_byte_take && (vid_count_reg != 4'h0))
    begin
      vbyte_next = vid_rdata[8*vid_idx_reg +: 8];
      vvalid_next = 1'b1;
      vid_idx_next = vid_idx_reg + 2'h1;
      if (vid_idx_reg == `VSF_BLOCK_LAST)
      begin
        vid_rd_next = vid_rd_reg + 3'h1;
        vid_count_next = vid_count_next - 4'h1;
        if ((vstate_reg == vsf_pkg::VSF_V_RUN) && (vid_rd_reg[1:0] == request_pointer) &&
            (blocks_next != `VSF_FILL_BLOCKS))
          blocks_next = blocks_next + 2'h1;
      end
    end
    unique case (vstate_reg)
      vsf_pkg::VSF_V_IDLE:
        if (hs_rise && first_display_raster)
        begin
          vstate_next = vsf_pkg::VSF_V_FILL;
          blocks_next = `VSF_FILL_BLOCKS;
          burst_next = 2'h0;
        end
      vsf_pkg::VSF_V_FILL:
        if (blocks_next == 2'h0)
          vstate_next = vsf_pkg::VSF_V_RUN;
      vsf_pkg::VSF_V_RUN:
        vstate_next = vsf_pkg::VSF_V_RUN;
      default:
        vstate_next = vsf_pkg::VSF_V_IDLE;
    endcase
    if (vs_active)
    begin
      vstate_next = vsf_pkg::VSF_V_IDLE;
      vid_count_next = 4'h0;
      vid_wr_next = 3'h0;
      vid_rd_next = 3'h0;
      vid_idx_next = 2'h0;
      blocks_next = 2'h0;
      burst_next = 2'h0;
      video_first_next = 1'b0;
    end
    // Held low while a block is owed and unstarted, a second block is owed, or the cursor refill is armed and unstarted
    vreq_n_next = !((blocks_next > ((burst_next != 2'h0) ? 2'h1 : 2'h0)) ||
                    (cur_left_next == `VSF_CUR_REFILL));
    if (vs_active)
      vreq_n_next = 1'b1;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vstate_reg <= vsf_pkg::VSF_V_IDLE;
      vid_count_reg <= 4'h0;
      vid_wr_reg <= 3'h0;
      vid_rd_reg <= 3'h0;
      vid_idx_reg <= 2'h0;
      blocks_reg <= 2'h0;
      burst_reg <= 2'h0;
      video_first_reg <= 1'b0;
      cur_left_reg <= 3'h0;
      cur_wr_reg <= 2'h0;
      cur_rd_reg <= 2'h0;
      cur_idx_reg <= 2'h0;
      cur_par_reg <= 1'b0;
      video_byte <= 8'h00;
      cursor_byte <= 8'h00;
      video_byte_valid <= 1'b0;
      cursor_byte_valid <= 1'b0;
      video_dma_request_n <= `VSF_PIN_IDLE;
    end
    else
    begin
      vstate_reg <= vstate_next;
      vid_count_reg <= vid_count_next;
      vid_wr_reg <= vid_wr_next;
      vid_rd_reg <= vid_rd_next;
      vid_idx_reg <= vid_idx_next;
      blocks_reg <= blocks_next;
      burst_reg <= burst_next;
      video_first_reg <= video_first_next;
      cur_left_reg <= cur_left_next;
      cur_wr_reg <= cur_wr_next;
      cur_rd_reg <= cur_rd_next;
      cur_idx_reg <= cur_idx_next;
      cur_par_reg <= cur_par_next;
      video_byte <= vbyte_next;
      cursor_byte <= cbyte_next;
      video_byte_valid <= vvalid_next;
      cursor_byte_valid <= cvalid_next;
      video_dma_request_n <= vreq_n_next;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_fill_fourth_done;
    vstate_reg == vsf_pkg::VSF_V_FILL && blocks_reg == 2'h1 && burst_reg == 2'h0;
  endsequence
  sequence s_fifth_ack;
    vid_ack_rise && route_vid && !vs_active && cur_left_reg != `VSF_CUR_REFILL;
  endsequence

  property p_snd_release;
    snd_ack_rise |=> sound_dma_request_n;
  endproperty
  a_snd_release: assert property (p_snd_release) else $error("sound request not released");
  property p_snd_last;
    byte_tick && snd_count_reg == 3'h1 && snd_idx_reg == `VSF_BLOCK_LAST && !snd_ack_rise
      |=> !sound_dma_request_n && sound_byte_strobe;
  endproperty
  a_snd_last: assert property (p_snd_last) else $error("sound request not raised");
  property p_snd_capture;
    snd_ack_rise && !byte_tick && snd_count_reg < `VSF_SND_FULL
      |=> snd_count_reg == $past(snd_count_reg) + 3'h1;
  endproperty
  a_snd_capture: assert property (p_snd_capture) else $error("sound word lost");
  property p_test_clear;
    !test_on |=> us_cnt_reg == 7'h00 && rate_cnt_reg == 8'h00 && !sound_byte_strobe;
  endproperty
  a_test_clear: assert property (p_test_clear) else $error("timing not cleared");
  property p_vsync_clear;
    vs_active |=> vid_count_reg == 4'h0 && video_dma_request_n;
  endproperty
  a_vsync_clear: assert property (p_vsync_clear) else $error("video not cleared");
  property p_fill_fifth;
    s_fill_fourth_done ##0 s_fifth_ack |=> video_dma_request_n;
  endproperty
  a_fill_fifth: assert property (p_fill_fifth) else $error("fill release wrong");
  property p_fill_early;
    vstate_reg == vsf_pkg::VSF_V_FILL && blocks_reg == `VSF_FILL_BLOCKS && !vs_active
      |=> !video_dma_request_n;
  endproperty
  a_fill_early: assert property (p_fill_early) else $error("fill released early");
  property p_cur_req;
    hs_fall && cursor_enable && cursor_raster && !cur_par_reg && !vs_active
      |=> !video_dma_request_n ##1 cur_left_reg != 3'h0;
  endproperty
  a_cur_req: assert property (p_cur_req) else $error("cursor request missing");
  property p_cur_alt;
    hs_fall && cursor_enable && cursor_raster |=> cur_par_reg != $past(cur_par_reg);
  endproperty
  a_cur_alt: assert property (p_cur_alt) else $error("cursor parity stuck");
  property p_ptr_req;
    video_byte_take && vid_count_reg != 4'h0 && vid_idx_reg == `VSF_BLOCK_LAST &&
      vstate_reg == vsf_pkg::VSF_V_RUN && vid_rd_reg[1:0] == request_pointer &&
      blocks_reg == 2'h0 && !vid_ack_rise && !vs_active |=> !video_dma_request_n;
  endproperty
  a_ptr_req: assert property (p_ptr_req) else $error("refill request missing");
  property p_reset_idle;
    $rose(resetn) |-> sound_dma_request_n && video_dma_request_n && vid_count_reg == 4'h0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset state wrong");
endmodule

// >>> sim/vsf_mem_ctrl_model.sv
// Behavioural memory controller that answers the sound and video DMA requests
`timescale 1ns/10ps
module vsf_mem_ctrl_model (
  input wire logic core_clk,
  input wire logic sound_dma_request_n,
  input wire logic video_dma_request_n,
  input wire logic horizontal_sync_n,
  output logic sound_dma_ack_n,
  output logic video_dma_ack_n,
  output logic [31:0] dma_data,
  output logic [31:0] sent_word,
  output logic [1:0] sent_kind,
  output logic sent_valid
);
  int seed = 82;
  bit bus_busy = 1'b0;
  logic [1:0] vkind;

  initial
  begin
    sound_dma_ack_n = 1'b1;
    video_dma_ack_n = 1'b1;
    dma_data = 32'h0000_0000;
    sent_word = 32'h0000_0000;
    sent_kind = 2'h0;
    sent_valid = 1'b0;
  end

  // Four strobed words; data held three cycles past each strobe rise, then inverted
  task automatic burst(input logic [1:0] kind);
    logic [31:0] w;
    while (bus_busy)
      @(negedge core_clk);
    bus_busy = 1'b1;
    repeat (4)
    begin
      w = $random(seed);
      dma_data = w;
      if (kind == 2'h0)
        sound_dma_ack_n = 1'b0;
      else
        video_dma_ack_n = 1'b0;
      repeat (2) @(negedge core_clk);
      sound_dma_ack_n = 1'b1;
      video_dma_ack_n = 1'b1;
      sent_word = w;
      sent_kind = kind;
      sent_valid = 1'b1;
      @(negedge core_clk);
      sent_valid = 1'b0;
      repeat (2) @(negedge core_clk);
      dma_data = ~w;
    end
    bus_busy = 1'b0;
  endtask

  // Sound refill, first word well inside the shortest byte period
  initial
  begin
    forever
    begin
      @(negedge core_clk);
      if (sound_dma_request_n === 1'b0)
      begin
        repeat (1 + {$random(seed)} % 200) @(negedge core_clk);
        burst(2'h0);
      end
    end
  end

  // Video or cursor refill, kept up while the request stays low
  initial
  begin
    forever
    begin
      @(negedge core_clk);
      if (video_dma_request_n === 1'b0)
      begin
        vkind = horizontal_sync_n ? 2'h1 : 2'h2;
        repeat (vkind == 2'h2 ? 2 : 105 + {$random(seed)} % 16) @(negedge core_clk);
        burst(vkind);
        repeat (4) @(negedge core_clk);
      end
    end
  end
endmodule

// >>> sim/vsf_top_tb_top.sv
// Self-checking bench for the sound, video and cursor DMA FIFO block
`timescale 1ns/10ps
module vsf_top_tb_top;
  logic core_clk, resetn, horizontal_sync_n, vertical_sync_n;
  logic sound_dma_ack_n, video_dma_ack_n, cursor_enable, cursor_raster;
  logic first_display_raster, video_byte_take, cursor_byte_take;
  logic [31:0] dma_data, sent_word;
  logic [8:0] sound_rate_reg;
  logic [1:0] request_pointer, sent_kind;
  logic sent_valid, sound_dma_request_n, video_dma_request_n;
  logic [7:0] sound_byte, video_byte, cursor_byte;
  logic sound_byte_strobe, video_byte_valid, cursor_byte_valid;
  logic [7:0] sq[$], vq[$], cq[$];
  int mismatches = 0;
  int samples_checked = 0;
  int vtake = 0;
  int vwords = 0;
  int strobes = 0;
  int s0;
  logic run_phase, req_low_seen;
  logic prev_vreq = 1'b1;

  vsf_top uut (.core_clk(core_clk), .resetn(resetn), .sound_dma_ack_n(sound_dma_ack_n),
    .video_dma_ack_n(video_dma_ack_n), .horizontal_sync_n(horizontal_sync_n),
    .vertical_sync_n(vertical_sync_n), .dma_data(dma_data), .sound_rate_reg(sound_rate_reg),
    .request_pointer(request_pointer), .cursor_enable(cursor_enable),
    .cursor_raster(cursor_raster), .first_display_raster(first_display_raster),
    .video_byte_take(video_byte_take), .cursor_byte_take(cursor_byte_take),
    .sound_dma_request_n(sound_dma_request_n), .video_dma_request_n(video_dma_request_n),
    .sound_byte(sound_byte), .sound_byte_strobe(sound_byte_strobe),
    .video_byte(video_byte), .video_byte_valid(video_byte_valid),
    .cursor_byte(cursor_byte), .cursor_byte_valid(cursor_byte_valid));

  vsf_mem_ctrl_model mc (.core_clk(core_clk), .sound_dma_request_n(sound_dma_request_n),
    .video_dma_request_n(video_dma_request_n), .horizontal_sync_n(horizontal_sync_n),
    .sound_dma_ack_n(sound_dma_ack_n), .video_dma_ack_n(video_dma_ack_n),
    .dma_data(dma_data), .sent_word(sent_word), .sent_kind(sent_kind),
    .sent_valid(sent_valid));

  task automatic chk_byte(input logic [7:0] exp, input logic [7:0] act);
    samples_checked++;
    if (exp !== act)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask

  task automatic chk_flag(input logic act, input logic exp);
    samples_checked++;
    if (exp !== act)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One byte take, ten cycles apart
  task automatic take(input bit cur);
    @(negedge core_clk);
    if (cur)
      cursor_byte_take = 1'b1;
    else
      video_byte_take = 1'b1;
    if (!cur)
      vtake++;
    @(negedge core_clk);
    cursor_byte_take = 1'b0;
    video_byte_take = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask

  // One horizontal sync pulse; notes whether the shared request fell inside it
  task automatic hpulse(input logic exp_req);
    @(negedge core_clk);
    req_low_seen = 1'b0;
    horizontal_sync_n = 1'b0;
    repeat (120) @(negedge core_clk);
    chk_flag(req_low_seen, exp_req);
    horizontal_sync_n = 1'b1;
    repeat (20) @(negedge core_clk);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever
      #5 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  // Expected bytes from each delivered word, low byte first
  always @(posedge core_clk)
    if (sent_valid === 1'b1)
    begin
      for (int b = 0; b < 4; b++)
        case (sent_kind)
          2'h0: sq.push_back(sent_word[8*b +: 8]);
          2'h1: vq.push_back(sent_word[8*b +: 8]);
          default: cq.push_back(sent_word[8*b +: 8]);
        endcase
      if (sent_kind == 2'h1)
        vwords++;
    end

  always @(negedge core_clk)
  begin
    if (sound_byte_strobe === 1'b1)
    begin
      strobes++;
      chk_byte(sq.size() > 0 ? sq.pop_front() : 8'hXX, sound_byte);
    end
    if (video_byte_valid === 1'b1)
      chk_byte(vq.size() > 0 ? vq.pop_front() : 8'hXX, video_byte);
    if (cursor_byte_valid === 1'b1)
      chk_byte(cq.size() > 0 ? cq.pop_front() : 8'hXX, cursor_byte);
    if (horizontal_sync_n === 1'b0 && video_dma_request_n === 1'b0)
      req_low_seen = 1'b1;
    if (run_phase && prev_vreq === 1'b1 && video_dma_request_n === 1'b0)
      chk_flag(vtake % 4 == 0 && (vtake - 1) / 4 % 4 == request_pointer, 1'b1);
    prev_vreq = video_dma_request_n;
  end

  initial
  begin
    resetn = 1'b0;
    horizontal_sync_n = 1'b1;
    vertical_sync_n = 1'b1;
    sound_rate_reg = 9'h102;
    request_pointer = 2'h0;
    cursor_enable = 1'b1;
    cursor_raster = 1'b0;
    first_display_raster = 1'b0;
    video_byte_take = 1'b0;
    cursor_byte_take = 1'b0;
    run_phase = 1'b0;
    req_low_seen = 1'b0;
    repeat (6) @(negedge core_clk);
    chk_flag(sound_dma_request_n, 1'b1);
    chk_flag(video_dma_request_n, 1'b1);
    resetn = 1'b1;
    repeat (600) @(negedge core_clk);
    s0 = strobes;
    repeat (3000) @(negedge core_clk);
    chk_flag(strobes - s0 >= 9 && strobes - s0 <= 11, 1'b1);
    sound_rate_reg = 9'h002;
    repeat (5) @(negedge core_clk);
    s0 = strobes;
    repeat (1000) @(negedge core_clk);
    chk_flag(strobes == s0, 1'b1);
    sound_rate_reg = 9'h104;
    s0 = strobes;
    repeat (5000) @(negedge core_clk);
    chk_flag(strobes - s0 >= 9 && strobes - s0 <= 11, 1'b1);
    cursor_raster = 1'b1;
    hpulse(1'b1);
    repeat (8) take(1'b1);
    hpulse(1'b0);
    repeat (8) take(1'b1);
    hpulse(1'b1);
    repeat (16) take(1'b1);
    cursor_enable = 1'b0;
    repeat (2) hpulse(1'b0);
    cursor_enable = 1'b1;
    cursor_raster = 1'b0;
    vertical_sync_n = 1'b0;
    repeat (40) @(negedge core_clk);
    chk_flag(video_dma_request_n, 1'b1);
    vertical_sync_n = 1'b1;
    first_display_raster = 1'b1;
    hpulse(1'b0);
    first_display_raster = 1'b0;
    for (int i = 0; i < 3000 && vwords < 8; i++)
      @(negedge core_clk);
    if (vwords < 8)
    begin
      mismatches++;
      end_of_test();
    end
    repeat (10) @(negedge core_clk);
    chk_flag(vwords == 8, 1'b1);
    chk_flag(video_dma_request_n, 1'b1);
    run_phase = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      request_pointer = p[1:0];
      repeat (32) take(1'b0);
    end
    repeat (200) @(negedge core_clk);
    chk_flag(cq.size() == 0, 1'b1);
    request_pointer = 2'h0;
    repeat (4) take(1'b0);
    chk_flag(video_dma_request_n, 1'b0);
    vertical_sync_n = 1'b0;
    repeat (200) @(negedge core_clk);
    chk_flag(video_dma_request_n, 1'b1);
    vq.delete();
    take(1'b0);
    chk_flag(video_dma_request_n, 1'b1);
    end_of_test();
  end
endmodule
